// ### hdl/presettable_bcd_binary_counter.sv
`timescale 1ns/10ps
module presettable_bcd_binary_counter
  import counter_pkg::*;
#(
  parameter bit DECADE      = 1'b1,
  parameter bit ASYNC_CLEAR = 1'b0
) (
  // clock and reset
  input  wire logic                  MCLK_I,
  input  wire logic                  RST_B_I,
  // counter controls
  input  wire logic                  COUNT_ENABLE_PARALLEL_I,
  input  wire logic                  COUNT_ENABLE_TRICKLE_I,
  input  wire logic                  ASYNC_CLEAR_N_I,
  input  wire logic                  SYNC_CLEAR_N_I,
  input  wire logic                  LOAD_ENABLE_N_I,
  input  wire logic [STATE_W-1:0]    PRESET_DATA_IN_I,
  // counter outputs
  output logic      [STATE_W-1:0]    STATE_OUT_O,
  output logic                       TERMINAL_COUNT_OUT_O,
  // axi4-lite write address
  input  wire logic                  S_AXI_AWVALID_I,
  output logic                       S_AXI_AWREADY_O,
  input  wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR_I,
  // axi4-lite write data
  input  wire logic                  S_AXI_WVALID_I,
  output logic                       S_AXI_WREADY_O,
  input  wire logic [AXI_DATA_W-1:0] S_AXI_WDATA_I,
  input  wire logic [3:0]            S_AXI_WSTRB_I,
  // axi4-lite write response
  output logic                       S_AXI_BVALID_O,
  input  wire logic                  S_AXI_BREADY_I,
  output logic      [1:0]            S_AXI_BRESP_O,
  // axi4-lite read address
  input  wire logic                  S_AXI_ARVALID_I,
  output logic                       S_AXI_ARREADY_O,
  input  wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR_I,
  // axi4-lite read data
  output logic                       S_AXI_RVALID_O,
  input  wire logic                  S_AXI_RREADY_I,
  output logic      [AXI_DATA_W-1:0] S_AXI_RDATA_O,
  output logic      [1:0]            S_AXI_RRESP_O
);

  // counter core
  logic [STATE_W-1:0]    state;
  logic [STATE_W-1:0]    next_state;
  logic                  at_max;
  step_ctrl_s            ctrl;
  mode_e                 mode;
  mode_e                 last_mode;
  logic                  aclr_n;

  // software control
  logic [STATE_W-1:0]    preset;
  logic [STATE_W-1:0]    match_value;
  logic                  cmd_load;
  logic                  cmd_clear;
  flags_s                flags;
  flags_s                flag_set;
  flags_s                flag_clr;
  logic [WRAPS_W-1:0]    wraps;

  // bus side
  logic                  aw_held;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic                  w_held;
  logic [AXI_DATA_W-1:0] w_data;
  logic [3:0]            w_strb;
  logic                  wr_fire;
  logic                  wr_hit;
  logic [DEC_W-1:0]      wr_ofs;
  logic                  rd_fire;
  logic                  rd_hit;
  logic [DEC_W-1:0]      rd_ofs;
  logic [AXI_DATA_W-1:0] rd_word;
  logic [AXI_DATA_W-1:0] next_rdata;

  // ---------------- counter controls ----------------

  // the unused clear of the other build option is ignored
  assign aclr_n = ASYNC_CLEAR ? ASYNC_CLEAR_N_I : 1'b1;

  always_comb begin
    ctrl.sclr  = (!ASYNC_CLEAR && !SYNC_CLEAR_N_I) || cmd_clear;
    ctrl.load  = !LOAD_ENABLE_N_I || cmd_load;
    ctrl.count = COUNT_ENABLE_PARALLEL_I
                 && COUNT_ENABLE_TRICKLE_I;
    // pin load takes its data from the pins, software load from preset
    ctrl.data  = !LOAD_ENABLE_N_I ? PRESET_DATA_IN_I : preset;
  end

  always_comb begin
    if (!aclr_n) begin
      mode = MODE_ACLR;
    end else if (ctrl.sclr) begin
      mode = MODE_SCLR;
    end else if (ctrl.load) begin
      mode = MODE_LOAD;
    end else if (ctrl.count) begin
      mode = MODE_COUNT;
    end else begin
      mode = MODE_HOLD;
    end
  end

  count_next #(
    .DECADE   (DECADE)
  ) u_next (
    .state_i  (state),
    .ctrl_i   (ctrl),
    .next_o   (next_state),
    .at_max_o (at_max)
  );

  // all four bits are clocked together; controls count only at the edge, except the clear pin in the ASYNC_CLEAR build
  state_flop #(
    .W        (STATE_W),
    .ASYNC    (ASYNC_CLEAR),
    .RST      (STATE_RST)
  ) u_state (
    .clk_i    (MCLK_I),
    .rst_n_i  (RST_B_I),
    .aclr_n_i (aclr_n),
    .d_i      (next_state),
    .q_o      (state)
  );

  assign STATE_OUT_O = state;

  // combinational decode: downstream stages take it as trickle enable
  assign TERMINAL_COUNT_OUT_O = COUNT_ENABLE_TRICKLE_I && at_max;

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      last_mode <= MODE_HOLD;
    end else begin
      last_mode <= mode;
    end
  end

  // ---------------- events and flags ----------------

  always_comb begin
    flag_set.wrap    = (mode == MODE_COUNT) && at_max;
    flag_set.illegal = DECADE && (state > DECADE_MAX);
    flag_set.loaded  = (mode == MODE_LOAD);
    flag_set.match   = (state == match_value);
    flag_clr         = '0;
    if (wr_fire && wr_hit && wr_ofs == OFS_FLAGS && w_strb[0]) begin
      flag_clr = w_data[3:0];
    end
  end

  // a set in the clearing cycle survives the clear
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      wraps <= '0;
    end else if (flag_set.wrap) begin
      wraps <= WRAPS_W'(wraps + 1'b1);
    end
  end

  // ---------------- axi4-lite write path ----------------

  assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = !w_held && !S_AXI_BVALID_O;
  assign wr_fire         = aw_held && w_held && !S_AXI_BVALID_O;
  assign wr_ofs          = {aw_addr[DEC_W-1:2], 2'b00};
  assign wr_hit          = (aw_addr[AXI_ADDR_W-1:DEC_W] == '0)
                           && (wr_ofs <= OFS_CONFIG);

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR_I;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA_I;
      w_strb <= S_AXI_WSTRB_I;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // ---------------- software registers ----------------

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      preset <= PRESET_RST;
    end else if (wr_fire && wr_hit && wr_ofs == OFS_PRESET && w_strb[0]) begin
      preset <= w_data[STATE_W-1:0];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      match_value <= MATCH_RST;
    end else if (wr_fire && wr_hit && wr_ofs == OFS_MATCH && w_strb[0]) begin
      match_value <= w_data[STATE_W-1:0];
    end
  end

  // command bits act at the edge after the write is taken, for one cycle
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      cmd_load  <= 1'b0;
      cmd_clear <= 1'b0;
    end else if (wr_fire && wr_hit && wr_ofs == OFS_CMD && w_strb[0]) begin
      cmd_load  <= w_data[CMD_LOAD_BIT];
      cmd_clear <= w_data[CMD_CLEAR_BIT];
    end else begin
      cmd_load  <= 1'b0;
      cmd_clear <= 1'b0;
    end
  end

  // ---------------- axi4-lite read path ----------------

  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
  assign rd_fire         = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign rd_ofs          = {S_AXI_ARADDR_I[DEC_W-1:2], 2'b00};
  assign rd_hit          = (S_AXI_ARADDR_I[AXI_ADDR_W-1:DEC_W] == '0)
                           && (rd_ofs <= OFS_CONFIG);

  always_comb begin
    rd_word = '0;
    case (rd_ofs)
      OFS_STATUS: begin
        rd_word[STATE_W-1:0]                     = state;
        rd_word[STATUS_TC_BIT]                   = TERMINAL_COUNT_OUT_O;
        rd_word[STATUS_MODE_LSB+2:STATUS_MODE_LSB] = last_mode;
      end
      OFS_PRESET: begin
        rd_word[STATE_W-1:0] = preset;
      end
      OFS_FLAGS: begin
        rd_word[3:0] = flags;
      end
      OFS_WRAPS: begin
        rd_word[WRAPS_W-1:0] = wraps;
      end
      OFS_MATCH: begin
        rd_word[STATE_W-1:0] = match_value;
      end
      OFS_CONFIG: begin
        rd_word[CFG_DECADE_BIT] = DECADE;
        rd_word[CFG_ASYNC_BIT]  = ASYNC_CLEAR;
      end
      default: begin
        rd_word = '0;
      end
    endcase
    next_rdata = rd_hit ? rd_word : '0;
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= '0;
      S_AXI_RRESP_O  <= RESP_OKAY;
    end else if (rd_fire) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O  <= next_rdata;
      S_AXI_RRESP_O  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

endmodule : presettable_bcd_binary_counter

// ### hdl/counter_pkg.sv
package counter_pkg;

  // counter geometry
  localparam int              STATE_W    = 4;
  localparam logic [3:0]      DECADE_MAX = 4'h9;
  localparam logic [3:0]      BINARY_MAX = 4'hF;
  localparam logic [3:0]      STATE_RST  = 4'h0;

  // bus geometry
  localparam int              AXI_ADDR_W = 32;
  localparam int              AXI_DATA_W = 32;
  localparam int              DEC_W      = 6;
  localparam int              WRAPS_W    = 16;

  // register byte offsets
  localparam logic [5:0]      OFS_STATUS = 6'h00;
  localparam logic [5:0]      OFS_PRESET = 6'h04;
  localparam logic [5:0]      OFS_CMD    = 6'h08;
  localparam logic [5:0]      OFS_FLAGS  = 6'h0C;
  localparam logic [5:0]      OFS_WRAPS  = 6'h10;
  localparam logic [5:0]      OFS_MATCH  = 6'h14;
  localparam logic [5:0]      OFS_CONFIG = 6'h18;

  // field positions
  localparam int              STATUS_TC_BIT   = 4;
  localparam int              STATUS_MODE_LSB = 5;
  localparam int              CMD_LOAD_BIT    = 0;
  localparam int              CMD_CLEAR_BIT   = 1;
  localparam int              CFG_DECADE_BIT  = 0;
  localparam int              CFG_ASYNC_BIT   = 1;

  // reset values
  localparam logic [3:0]      PRESET_RST = 4'h0;
  localparam logic [3:0]      MATCH_RST  = 4'hF;

  // bus responses
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_HOLD  = 3'b000,
    MODE_COUNT = 3'b001,
    MODE_LOAD  = 3'b010,
    MODE_SCLR  = 3'b011,
    MODE_ACLR  = 3'b100
  } mode_e;

  typedef struct packed {
    logic       sclr;
    logic       load;
    logic       count;
    logic [3:0] data;
  } step_ctrl_s;

  typedef struct packed {
    logic match;
    logic loaded;
    logic illegal;
    logic wrap;
  } flags_s;

endpackage : counter_pkg

// ### hdl/count_next.sv
`timescale 1ns/10ps
module count_next
  import counter_pkg::*;
#(
  parameter bit DECADE = 1'b1
) (
  // present state and requested step
  input  wire logic [STATE_W-1:0] state_i,
  input  wire step_ctrl_s         ctrl_i,
  // next state and maximum decode
  output logic      [STATE_W-1:0] next_o,
  output logic                    at_max_o
);

  logic [STATE_W-1:0] inc;

  always_comb begin
    if (DECADE) begin
      at_max_o = (state_i == DECADE_MAX);
      if (at_max_o) begin
        inc = STATE_RST;
      end else if (state_i > DECADE_MAX && state_i[0]) begin
        inc = {1'b0, 3'(state_i[2:0] + 3'h1)};
      end else begin
        inc = 4'(state_i + 4'h1);
      end
    end else begin
      at_max_o = (state_i == BINARY_MAX);
      inc      = 4'(state_i + 4'h1);
    end
  end

  always_comb begin
    if (ctrl_i.sclr) begin
      next_o = STATE_RST;
    end else if (ctrl_i.load) begin
      next_o = ctrl_i.data;
    end else if (ctrl_i.count) begin
      next_o = inc;
    end else begin
      next_o = state_i;
    end
  end

endmodule : count_next

// ### hdl/state_flop.sv
`timescale 1ns/10ps
module state_flop #(
  parameter int         W     = 4,
  parameter bit         ASYNC = 1'b0,
  parameter logic [3:0] RST   = 4'h0
) (
  // clock and resets
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         aclr_n_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  generate
    if (ASYNC) begin : g_async
      always_ff @(posedge clk_i or negedge aclr_n_i) begin
        if (!aclr_n_i) begin
          q_o <= W'(RST);
        end else if (!rst_n_i) begin
          q_o <= W'(RST);
        end else begin
          q_o <= d_i;
        end
      end
    end else begin : g_sync
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          q_o <= W'(RST);
        end else begin
          q_o <= d_i;
        end
      end
    end
  endgenerate

endmodule : state_flop

// ### test/stage_model.sv
`timescale 1ns/10ps
module stage_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // enable from the lower stage
  input  wire logic       en_i,
  output logic      [3:0] st_o
);
  // lower stage terminal count only enables, never clocks this stage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_o <= 4'h0;
    end else if (en_i) begin
      st_o <= (st_o == 4'h9) ? 4'h0 : st_o + 4'h1;
    end
  end
endmodule : stage_model

// ### test/counter_monitor.sv
`timescale 1ns/10ps
module counter_monitor
  import counter_pkg::*;
#(
  parameter bit DECADE      = 1'b1,
  parameter bit ASYNC_CLEAR = 1'b0
) (
  // clock and reset
  input wire logic               MCLK_I,
  input wire logic               RST_B_I,
  // counter pins
  input wire logic               COUNT_ENABLE_PARALLEL_I,
  input wire logic               COUNT_ENABLE_TRICKLE_I,
  input wire logic               SYNC_CLEAR_N_I,
  input wire logic               LOAD_ENABLE_N_I,
  input wire logic [STATE_W-1:0] PRESET_DATA_IN_I,
  input wire logic [STATE_W-1:0] STATE_OUT_O,
  input wire logic               TERMINAL_COUNT_OUT_O,
  // write response
  input wire logic               S_AXI_BVALID_O
);
  localparam logic [3:0] MAXV = DECADE ? DECADE_MAX : BINARY_MAX;
  logic bv_q;
  logic cmd;
  logic en;
  logic cnt;
  always_ff @(posedge MCLK_I) begin
    bv_q <= S_AXI_BVALID_O;
  end
  // a software command acts at the edge after its response rises
  assign cmd = S_AXI_BVALID_O & ~bv_q;
  assign en  = COUNT_ENABLE_PARALLEL_I & COUNT_ENABLE_TRICKLE_I;
  assign cnt = SYNC_CLEAR_N_I & LOAD_ENABLE_N_I & en & ~cmd;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  sequence count_two;
    cnt ##1 cnt;
  endsequence
  sequence reach_max;
    cnt && COUNT_ENABLE_TRICKLE_I && STATE_OUT_O == MAXV - 4'h1 ##1 COUNT_ENABLE_TRICKLE_I;
  endsequence
  a_max_wrap: assert property (cnt && STATE_OUT_O == MAXV |=> STATE_OUT_O == STATE_RST)
    else $error("counter did not wrap to zero");
  a_count_step: assert property (cnt && STATE_OUT_O < MAXV |=>
    STATE_OUT_O == $past(STATE_OUT_O) + 4'h1) else $error("count step wrong");
  a_hold_state: assert property (SYNC_CLEAR_N_I && LOAD_ENABLE_N_I && !en && !cmd |=>
    $stable(STATE_OUT_O)) else $error("state moved while holding");
  a_sync_clear: assert property (!ASYNC_CLEAR && !SYNC_CLEAR_N_I |=> STATE_OUT_O == STATE_RST)
    else $error("sync clear missed");
  a_pin_load: assert property ((ASYNC_CLEAR || SYNC_CLEAR_N_I) && !LOAD_ENABLE_N_I && !cmd |=>
    STATE_OUT_O == $past(PRESET_DATA_IN_I)) else $error("parallel load wrong");
  a_term_decode: assert property (TERMINAL_COUNT_OUT_O ==
    (COUNT_ENABLE_TRICKLE_I && STATE_OUT_O == MAXV)) else $error("terminal decode wrong");
  a_term_ahead: assert property (reach_max |-> TERMINAL_COUNT_OUT_O)
    else $error("terminal count late");
  a_illegal_rejoin: assert property ((DECADE && STATE_OUT_O > DECADE_MAX) ##0 count_two |=>
    STATE_OUT_O <= DECADE_MAX) else $error("illegal state kept");
endmodule : counter_monitor

bind presettable_bcd_binary_counter counter_monitor #(
  .DECADE(DECADE),
  .ASYNC_CLEAR(ASYNC_CLEAR)
) i_counter_monitor (
  .MCLK_I,
  .RST_B_I,
  .COUNT_ENABLE_PARALLEL_I,
  .COUNT_ENABLE_TRICKLE_I,
  .SYNC_CLEAR_N_I,
  .LOAD_ENABLE_N_I,
  .PRESET_DATA_IN_I,
  .STATE_OUT_O,
  .TERMINAL_COUNT_OUT_O,
  .S_AXI_BVALID_O
);

// ### test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import counter_pkg::*;
  logic        clk, rst_n, en_par, en_tr, sc, ld, term, aw, wv, br, ar, rr;
  logic        aw_rdy, w_rdy, bv, ar_rdy, rv;
  logic [3:0]  pd, st, hi, exp_st, exp_hi;
  logic [31:0] awa, wd, ara, rdata, rdat;
  logic [1:0]  bresp, rresp, resp;
  int          n_fail, checks, seed, exp_wr;

  stage_model i_stage_model (.clk_i(clk), .rst_n_i(rst_n), .en_i(term), .st_o(hi));

  presettable_bcd_binary_counter #(.DECADE(1'b1), .ASYNC_CLEAR(1'b0))
  i_presettable_bcd_binary_counter (
    .MCLK_I(clk), .RST_B_I(rst_n), .COUNT_ENABLE_PARALLEL_I(en_par),
    .COUNT_ENABLE_TRICKLE_I(en_tr), .ASYNC_CLEAR_N_I(1'b1), .SYNC_CLEAR_N_I(sc),
    .LOAD_ENABLE_N_I(ld), .PRESET_DATA_IN_I(pd), .STATE_OUT_O(st),
    .TERMINAL_COUNT_OUT_O(term), .S_AXI_AWVALID_I(aw), .S_AXI_AWREADY_O(aw_rdy),
    .S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(w_rdy),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(br), .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(ar),
    .S_AXI_ARREADY_O(ar_rdy), .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  function automatic logic [3:0] nxt(input logic [3:0] s, input logic c, l, n,
                                     input logic [3:0] d);
    if (!c) return 4'h0;
    if (!l) return d;
    if (!n) return s;
    if (s == 4'h9) return 4'h0;
    if (s > 4'h9 && s[0]) return {1'b0, s[2:0] + 3'h1};
    return s + 4'h1;
  endfunction : nxt

  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    {aw, wv, br} <= 3'b111;
    awa <= a;
    wd <= d;
    do begin
      @(posedge clk);
      if (aw && aw_rdy) aw <= 1'b0;
      if (wv && w_rdy) wv <= 1'b0;
    end while (!(br && bv));
    resp = bresp;
    br <= 1'b0;
  endtask : wr

  task rd(input logic [31:0] a);
    @(posedge clk);
    {ar, rr} <= 2'b11;
    ara <= a;
    do begin
      @(posedge clk);
      if (ar && ar_rdy) ar <= 1'b0;
    end while (!(rr && rv));
    rdat = rdata;
    resp = rresp;
    rr <= 1'b0;
  endtask : rd

  task run(input int n, input bit rnd);
    logic [31:0] v;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (en_tr && exp_st == 4'h9) exp_hi = (exp_hi == 4'h9) ? 4'h0 : exp_hi + 4'h1;
      if (sc && ld && en_par && en_tr && exp_st == 4'h9) exp_wr++;
      exp_st = nxt(exp_st, sc, ld, en_par & en_tr, pd);
      if (rnd) begin
        v = $random(seed);
        {en_par, en_tr} <= {v[0], v[1] | v[2]};
        {sc, ld} <= {|v[5:4], |v[7:6]};
        pd <= v[11:8];
      end
      #1;
      chk("state", exp_st, st);
      chk("term", en_tr && exp_st == 4'h9, term);
    end
  endtask : run

  task stop_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    $display("ERROR watchdog expected done seen hang");
    stop_test();
  end

  initial begin
    seed = 32'h72f9;
    {rst_n, en_par, en_tr, sc, ld, aw, wv, br, ar, rr} = 10'b0001100000;
    {pd, exp_st, exp_hi} = 12'h0;
    {awa, wd, ara} = 96'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(32'(OFS_CONFIG));
    chk("config", 32'h1, rdat);
    rd(32'(OFS_MATCH));
    chk("match", 32'(MATCH_RST), rdat);
    rd(32'(OFS_PRESET));
    chk("preset", 32'(PRESET_RST), rdat);
    rd(32'h40);
    chk("rresp", 32'(RESP_SLVERR), resp);
    wr(32'h40, 32'h0);
    chk("bresp", 32'(RESP_SLVERR), resp);
    $display("test registers done");
    {en_par, en_tr, ld} <= 3'b110;
    run(1, 1'b0);
    ld <= 1'b1;
    run(25, 1'b0);
    chk("upper stage", exp_hi, hi);
    $display("test cascade done");
    run(400, 1'b1);
    {en_par, en_tr, sc, ld} <= 4'b0011;
    run(1, 1'b0);
    $display("test random done");
    wr(32'(OFS_PRESET), 32'h6);
    wr(32'(OFS_CMD), 32'h1);
    @(posedge clk);
    #1;
    chk("soft load", 32'h6, st);
    wr(32'(OFS_CMD), 32'h2);
    rd(32'(OFS_STATUS));
    chk("status", 32'h0, rdat & 32'h1F);
    rd(32'(OFS_WRAPS));
    chk("wraps", exp_wr, rdat);
    wr(32'(OFS_MATCH), 32'h0);
    wr(32'(OFS_FLAGS), 32'hF);
    rd(32'(OFS_FLAGS));
    chk("flags", 32'h8, rdat);
    $display("test commands done");
    stop_test();
  end
endmodule : tb_top
